/* File: rtl/rtc_irq_output_config.sv */
/*
 APB register file, interrupt gating, alarm compare and pin drivers of
 an RTC with two timers.
 Assumes core events arrive synchronous to ref_clk and that the pad ring
 resolves each out/oe pair into a wire.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module rtc_irq_output_config
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rtc_irq_pkg::core_evt_s evt,
   input wire logic [rtc_irq_pkg::NUM_CMP*8-1:0] clockCounters,
   output rtc_irq_pkg::pin_drive_s timer1_output_pin,
   output rtc_irq_pkg::pin_drive_s main_interrupt_pin,
   output rtc_irq_pkg::pin_drive_s multi_function_output,
   output logic alarmStatus,
   output logic lowBattery
);
   import rtc_irq_pkg::*;

   function automatic pin_drive_s drive_pin(input logic asserted,
      input logic activeHigh, input logic pushPull);
      logic level;
      pin_drive_s d;
      level = activeHigh ? asserted : ~asserted;
      d.out = pushPull ? level : 1'b0;
      d.oe = pushPull | ~level;
      return d;
   endfunction : drive_pin

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   logic [7:0] pinCfg;
   logic [7:0] perEn;
   logic [7:0] almEn;
   logic [7:0] route;
   logic [7:0] cmpByte [NUM_CMP];
   logic [NUM_SRC-1:0] irqSrc;
   logic mainLevel;
   logic secondLevel;

   wire setupPhase = psel & ~penable;
   wire writeEn = psel & penable & pwrite & pstrb[0];
   wire hitCfg = paddr == OFS_PIN_CFG;
   wire hitPer = paddr == OFS_PER_EN;
   wire hitAlm = paddr == OFS_ALM_EN;
   wire hitRoute = paddr == OFS_ROUTE;
   wire hitStatus = paddr == OFS_STATUS;
   wire [7:0] cmpOfs = paddr - OFS_CMP_BASE;
   wire hitCmp = paddr >= OFS_CMP_BASE && cmpOfs[1:0] == 2'b00
      && cmpOfs[7:2] < 6'(NUM_CMP);
   wire [2:0] cmpIdx = cmpOfs[4:2];
   wire mapped = hitCfg | hitPer | hitAlm | hitRoute | hitStatus | hitCmp;
   wire [7:0] statusWord = {secondLevel, mainLevel, lowBattery,
      irqSrc[SRC_POWER_FAIL_INPUT], alarmStatus, irqSrc[SRC_T1], irqSrc[SRC_T0],
      irqSrc[SRC_PER]};
   wire [7:0] readByte = hitCfg ? pinCfg :
      hitPer ? perEn :
      hitAlm ? almEn :
      hitRoute ? {3'b000, route[NUM_SRC-1:0]} :
      hitStatus ? statusWord :
      hitCmp ? cmpByte[cmpIdx] : 8'h00;

   // Zero wait states; the status read is taken at the setup edge
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         prdata <= 32'h0000_0000;
      else if (ce && setupPhase)
         prdata <= {24'h00_0000, readByte};
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         pinCfg <= RST_REG;
         perEn <= RST_REG;
         almEn <= RST_REG;
         route <= RST_REG;
      end
      else if (ce && writeEn)
      begin
         if (hitCfg)
            pinCfg <= pwdata[7:0];
         if (hitPer)
            perEn <= pwdata[7:0];
         if (hitAlm)
            almEn <= pwdata[7:0];
         if (hitRoute)
            route <= {3'b000, pwdata[NUM_SRC-1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Compare bytes and comparators
   logic [NUM_CMP-1:0] cmpEqual;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++)
      begin : g_cmp
         always_ff @(posedge ref_clk)
         begin
            if (!nrst)
               cmpByte[gi] <= RST_REG;
            else if (ce && writeEn && hitCmp && cmpIdx == 3'(gi))
               cmpByte[gi] <= pwdata[7:0];
         end
         // Disabled comparator sits in the always-equal state
         assign cmpEqual[gi] = ~almEn[gi]
            | (clockCounters[gi*8 +: 8] == cmpByte[gi]);
      end
   endgenerate

   // No enable at all keeps the alarm flag low
   assign alarmStatus = &cmpEqual & |almEn[5:0];
   assign lowBattery = almEn[EN1_POWER_FAIL_INPUT] & evt.lowBatteryRaw;

   ////////////////////////////////////////////////////////////////////
   // Interrupt gating and routing
   logic [NUM_SRC-1:0] next_irqSrc;
   // Rollover pulses are gated, not timed, so an enable set mid-period
   // gives one short first period and regular spacing afterwards.
   assign next_irqSrc[SRC_PER] =
      |(evt.rollover & perEn[5:0]);
   assign next_irqSrc[SRC_T0] = evt.timer0Irq & perEn[EN0_T0];
   assign next_irqSrc[SRC_T1] = evt.timer1Irq & perEn[EN0_T1];
   assign next_irqSrc[SRC_ALARM] = alarmStatus & almEn[EN1_ALARM];
   assign next_irqSrc[SRC_POWER_FAIL_INPUT] = almEn[EN1_POWER_FAIL_INPUT]
      & ~evt.power_fail_input_n;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         irqSrc <= '0;
      else if (ce)
         irqSrc <= next_irqSrc;
   end

   assign mainLevel = |(irqSrc & ~route[NUM_SRC-1:0]);
   assign secondLevel = |(irqSrc & route[NUM_SRC-1:0]);

   ////////////////////////////////////////////////////////////////////
   // Pin drivers
   logic [1:0] mfoSel;
   logic mfoSignal;
   logic intPushPull;
   logic mfoPushPull;
   pin_drive_s next_t1;
   pin_drive_s next_int;
   pin_drive_s next_mfo;

   assign mfoSel = pinCfg[CFG_MFO_SEL_HI:CFG_MFO_SEL_LO];
   assign mfoSignal = mfoSel[1] ? evt.crystalClk :
      mfoSel[0] ? evt.timer0Wave : secondLevel;
   // Standby supplies may be down, so the interrupt and multi-function pins only pull down
   assign intPushPull = pinCfg[CFG_INT_PP] & ~evt.standby;
   assign mfoPushPull = pinCfg[CFG_MFO_PP] & ~evt.standby;
   assign next_t1 = drive_pin(evt.timer1Active, pinCfg[CFG_T1_POL],
      pinCfg[CFG_T1_PP]);
   assign next_int = drive_pin(mainLevel, pinCfg[CFG_INT_POL],
      intPushPull);
   assign next_mfo = drive_pin(mfoSignal, pinCfg[CFG_MFO_POL],
      mfoPushPull);

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         timer1_output_pin <= '0;
         main_interrupt_pin <= '0;
         multi_function_output <= '0;
      end
      else if (ce)
      begin
         timer1_output_pin <= next_t1;
         main_interrupt_pin <= next_int;
         multi_function_output <= next_mfo;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   t1_polarity_a: assert property ($past(ce && pinCfg[CFG_T1_PP])
      |-> timer1_output_pin.out
         == ($past(evt.timer1Active) ~^ $past(pinCfg[CFG_T1_POL])))
      else $error("timer-1 pin level wrong for polarity");
   t1_open_drain_a: assert property (
      $past(ce && !pinCfg[CFG_T1_PP])
      |-> !timer1_output_pin.out
         && timer1_output_pin.oe
            == ($past(evt.timer1Active) ^ $past(pinCfg[CFG_T1_POL])))
      else $error("timer-1 open drain pin misdriven");
   int_polarity_a: assert property ($past(ce && intPushPull)
      |-> main_interrupt_pin.oe && main_interrupt_pin.out
         == ($past(mainLevel) ~^ $past(pinCfg[CFG_INT_POL])))
      else $error("interrupt pin level wrong for polarity");
   int_standby_od_a: assert property ($past(ce)
      && $past(!pinCfg[CFG_INT_PP] || evt.standby)
      |-> !main_interrupt_pin.out)
      else $error("interrupt pin driven high while open drain");
   mfo_crystal_a: assert property (
      $past(ce && mfoSel[1] && mfoPushPull)
      |-> multi_function_output.out
         == ($past(evt.crystalClk) ~^ $past(pinCfg[CFG_MFO_POL])))
      else $error("multi-function pin not carrying crystal");
   mfo_standby_od_a: assert property ($past(ce && evt.standby)
      |-> !multi_function_output.out)
      else $error("multi-function pin pushed in standby");
   periodic_off_a: assert property (ce && perEn[5:0] == 6'h00
      |=> !irqSrc[SRC_PER] && !(statusWord[0]))
      else $error("periodic interrupt with all enables clear");
   periodic_on_a: assert property (
      ce && |(evt.rollover & perEn[5:0])
      |=> irqSrc[SRC_PER] ##0 (mainLevel || secondLevel))
      else $error("enabled rollover lost");
   timer_gate_a: assert property (ce && !perEn[EN0_T1]
      |=> !irqSrc[SRC_T1])
      else $error("timer 1 interrupt while disabled");
   alarm_gate_a: assert property (ce && !almEn[EN1_ALARM]
      |=> !irqSrc[SRC_ALARM])
      else $error("alarm interrupt while disabled");
   alarm_none_a: assert property (almEn[5:0] == 6'h00
      |-> !alarmStatus)
      else $error("alarm flag with all compares off");
   power_fail_input_irq_a: assert property (ce && almEn[EN1_POWER_FAIL_INPUT]
      && !evt.power_fail_input_n |=> irqSrc[SRC_POWER_FAIL_INPUT])
      else $error("power-fail interrupt missing");
   low_batt_a: assert property (!almEn[EN1_POWER_FAIL_INPUT] |-> !lowBattery)
      else $error("low battery shown while detection disabled");
   route_mfo_a: assert property (route[NUM_SRC-1:0] == 5'h1f
      && irqSrc != '0 |-> !mainLevel && secondLevel)
      else $error("routed interrupt reached main pin");

   periodic_fire_c: cover property (ce && next_irqSrc[SRC_PER]);
   alarm_fire_c: cover property (ce && next_irqSrc[SRC_ALARM]);
   power_fail_input_mfo_c: cover property (irqSrc[SRC_POWER_FAIL_INPUT] && route[SRC_POWER_FAIL_INPUT]);
   status_read_c: cover property (setupPhase && hitStatus && !pwrite);
endmodule : rtc_irq_output_config

/* File: shared/rtc_irq_pkg.sv */
/*
 Shared constants and carriers for the RTC pin and interrupt-enable block.
 Assumes a 32-bit APB slave with byte offsets on aligned words.
*/
package rtc_irq_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PIN_CFG = 8'h00;
   localparam logic [7:0] OFS_PER_EN = 8'h04;
   localparam logic [7:0] OFS_ALM_EN = 8'h08;
   localparam logic [7:0] OFS_ROUTE = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CMP_BASE = 8'h20;
   localparam int NUM_CMP = 6;
   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   // pin_output_config fields
   localparam int CFG_T1_POL = 0;
   localparam int CFG_T1_PP = 1;
   localparam int CFG_INT_POL = 2;
   localparam int CFG_INT_PP = 3;
   localparam int CFG_MFO_POL = 4;
   localparam int CFG_MFO_PP = 5;
   localparam int CFG_MFO_SEL_LO = 6;
   localparam int CFG_MFO_SEL_HI = 7;
   // periodic_timer_irq_enable fields
   localparam int EN0_T0 = 6;
   localparam int EN0_T1 = 7;
   // alarm_powerfail_irq_enable fields
   localparam int EN1_ALARM = 6;
   localparam int EN1_POWER_FAIL_INPUT = 7;
   // Interrupt source order, also the routing bit positions
   localparam int SRC_POWER_FAIL_INPUT = 0;
   localparam int SRC_PER = 1;
   localparam int SRC_ALARM = 2;
   localparam int SRC_T0 = 3;
   localparam int SRC_T1 = 4;
   localparam int NUM_SRC = 5;

   typedef struct packed {
      logic [5:0] rollover;
      logic timer0Irq;
      logic timer1Irq;
      logic timer0Wave;
      logic timer1Active;
      logic crystalClk;
      logic power_fail_input_n;
      logic lowBatteryRaw;
      logic standby;
   } core_evt_s;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_s;
endpackage : rtc_irq_pkg

/* File: verif/host_pin_model.sv */
/*
 Host side of the pins: resolves each out/oe pair into a wire level.
 Assumes board pull-ups on the three output pins.
*/
`timescale 1ns/1ps
module host_pin_model
(
   input wire rtc_irq_pkg::pin_drive_s timer1_output_pin,
   input wire rtc_irq_pkg::pin_drive_s main_interrupt_pin,
   input wire rtc_irq_pkg::pin_drive_s multi_function_output,
   output logic t1Wire,
   output logic intWire,
   output logic mfoWire
);
   import rtc_irq_pkg::*;
   // A released open-drain pin floats up, never keeps its last value
   assign t1Wire = timer1_output_pin.oe ? timer1_output_pin.out : 1'b1;
   assign intWire = main_interrupt_pin.oe ? main_interrupt_pin.out : 1'b1;
   assign mfoWire = multi_function_output.oe ?
      multi_function_output.out : 1'b1;
endmodule : host_pin_model

/* File: verif/tb.sv */
/*
 Self-checking bench for the pin and interrupt-enable block.
 Assumes zero-wait APB and pins settled three edges after any change.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) \
   total_checks++; \
   if ((s) !== (e)) \
   begin \
      n_fail++; \
      $display("wrong value %s exp %h got %h", nm, e, s); \
   end
module tb;
   import rtc_irq_pkg::*;
   logic ref_clk, nrst, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdVal, v;
   logic [3:0] pstrb;
   logic errVal, alarmStatus, lowBattery, t1Wire, intWire, mfoWire, eb;
   pin_drive_s ex;
   logic [47:0] clockCounters;
   logic [63:0] cnt;
   core_evt_s evt;
   pin_drive_s timer1_output_pin, main_interrupt_pin, multi_function_output;
   int seed, i, c, a, n_fail, total_checks;
   logic [7:0] rwAddr [9] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h28,
      8'h2c, 8'h30, 8'h34};
   rtc_irq_output_config dut_u
   (
      .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .clockCounters(clockCounters),
      .timer1_output_pin(timer1_output_pin),
      .main_interrupt_pin(main_interrupt_pin),
      .multi_function_output(multi_function_output),
      .alarmStatus(alarmStatus), .lowBattery(lowBattery)
   );
   host_pin_model host_u
   (
      .timer1_output_pin(timer1_output_pin),
      .main_interrupt_pin(main_interrupt_pin),
      .multi_function_output(multi_function_output),
      .t1Wire(t1Wire), .intWire(intWire), .mfoWire(mfoWire)
   );
   ////////////////////////////////////////////////////////////////////////
   function automatic pin_drive_s pexp(input logic on, input logic pol,
      input logic pp);
      logic lvl;
      pin_drive_s d;
      lvl = pol ? on : ~on;
      // Push-pull drives the level; open drain only pulls low
      d.out = pp & lvl;
      d.oe = pp | ~lvl;
      return d;
   endfunction : pexp
   task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdVal = prdata;
      errVal = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Ends on a falling edge; callers realign before driving again
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle
   task automatic per_pulse(input logic [5:0] m, input logic e);
      logic seen;
      seen = 1'b0;
      @(posedge ref_clk);
      evt.rollover <= m;
      @(posedge ref_clk);
      evt.rollover <= 6'h00;
      // The pin pulse stands one cycle, so look at every falling edge
      repeat (4)
      begin
         @(negedge ref_clk);
         seen = seen | intWire;
      end
      `CHK("periodic", e, seen)
   endtask : per_pulse
   task automatic alm(input logic [7:0] en, input logic [7:0] b2,
      input logic ea, input logic ei);
      apb(1'b1, OFS_ALM_EN, {24'h0, en});
      apb(1'b1, 8'h28, {24'h0, b2});
      settle();
      `CHK("alarm", ea, alarmStatus)
      `CHK("alarm irq", ei, main_interrupt_pin.out)
   endtask : alm
   task automatic close_out;
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #(25 * 20000);
      n_fail++;
      close_out();
   end
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      pstrb = 4'hf;
      seed = 81;
      n_fail = 0;
      total_checks = 0;
      evt = '0;
      evt.power_fail_input_n = 1'b1;
      clockCounters = '0;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      for (i = 0; i < 3; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK("reset", 32'h0, rdVal)
      end
      apb(1'b0, 8'hfc, 32'h0);
      `CHK("unmapped", 1'b1, errVal)
      `CHK("unmapped data", 32'h0, rdVal)
      for (i = 0; i < 9; i++)
      begin
         v = $random(seed);
         apb(1'b1, rwAddr[i], v);
         apb(1'b0, rwAddr[i], 32'h0);
         `CHK("rw", {24'h0, v[7:0]}, rdVal)
      end
      pstrb <= 4'h0;
      apb(1'b1, 8'h34, ~v);
      pstrb <= 4'hf;
      apb(1'b0, 8'h34, 32'h0);
      `CHK("strobe", {24'h0, v[7:0]}, rdVal)
      // Routing read-back; a write with the clock enable low must not land
      v = $random(seed);
      apb(1'b1, OFS_ROUTE, v);
      ce <= 1'b0;
      apb(1'b1, OFS_ROUTE, ~v);
      ce <= 1'b1;
      apb(1'b0, OFS_ROUTE, 32'h0);
      `CHK("route", {27'h0, v[4:0]}, rdVal)
      apb(1'b1, OFS_PER_EN, 32'hc0);
      apb(1'b1, OFS_ALM_EN, 32'h80);
      apb(1'b1, OFS_ROUTE, 32'h01);
      for (c = 0; c < 64; c++)
      begin
         apb(1'b1, OFS_PIN_CFG, 32'(c));
         for (a = 0; a < 2; a++)
         begin
            @(posedge ref_clk);
            evt.timer0Irq <= a[0];
            evt.timer1Active <= a[0];
            evt.power_fail_input_n <= ~a[0];
            settle();
            ex = pexp(a[0], c[0], c[1]);
            `CHK("t1", ex, timer1_output_pin)
            ex = pexp(a[0], c[2], c[3]);
            `CHK("int", ex, main_interrupt_pin)
            ex = pexp(a[0], c[4], c[5]);
            `CHK("mfo", ex, multi_function_output)
         end
      end
      for (i = 0; i < 8; i++)
      begin
         v = $random(seed);
         apb(1'b1, OFS_PIN_CFG, {24'h0, 2'(i), 6'h30});
         evt.timer0Wave <= v[0];
         evt.crystalClk <= v[1];
         settle();
         eb = i[1] ? v[1] : (i[0] ? v[0] : 1'b1);
         `CHK("mfo sel", eb, mfoWire)
      end
      apb(1'b1, OFS_PIN_CFG, 32'h3f);
      evt.standby <= 1'b1;
      settle();
      ex = pexp(1'b1, 1'b1, 1'b0);
      `CHK("sb int", ex, main_interrupt_pin)
      `CHK("sb mfo", ex, multi_function_output)
      ex = pexp(1'b1, 1'b1, 1'b1);
      `CHK("sb t1", ex, timer1_output_pin)
      @(posedge ref_clk);
      evt <= '{power_fail_input_n: 1'b1, default: '0};
      apb(1'b1, OFS_PIN_CFG, 32'h0c);
      apb(1'b1, OFS_ALM_EN, 32'h0);
      apb(1'b1, OFS_ROUTE, 32'h0);
      for (i = 0; i < 6; i++)
      begin
         apb(1'b1, OFS_PER_EN, 32'(1 << i));
         per_pulse(6'(1 << i), 1'b1);
         per_pulse(~6'(1 << i), 1'b0);
      end
      apb(1'b1, OFS_PER_EN, 32'h0);
      per_pulse(6'h3f, 1'b0);
      @(posedge ref_clk);
      evt.timer1Irq <= 1'b1;
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, OFS_PER_EN, 32'(8'h40 << i));
         settle();
         `CHK("timer irq", i[0], main_interrupt_pin.out)
      end
      apb(1'b1, OFS_PER_EN, 32'h0);
      cnt = {$random(seed), $random(seed)};
      clockCounters <= cnt[47:0];
      for (i = 0; i < 6; i++)
         apb(1'b1, 8'(OFS_CMP_BASE + 4 * i), {24'h0, cnt[8 * i +: 8]});
      alm(8'h7f, cnt[23:16], 1'b1, 1'b1);
      alm(8'h3f, cnt[23:16], 1'b1, 1'b0);
      alm(8'h3f, ~cnt[23:16], 1'b0, 1'b0);
      alm(8'h3b, ~cnt[23:16], 1'b1, 1'b0);
      alm(8'h00, cnt[23:16], 1'b0, 1'b0);
      @(posedge ref_clk);
      evt.lowBatteryRaw <= 1'b1;
      apb(1'b1, OFS_ALM_EN, 32'h80);
      settle();
      `CHK("lowbat on", 1'b1, lowBattery)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", 32'h20, rdVal)
      apb(1'b1, OFS_ALM_EN, 32'h0);
      settle();
      `CHK("lowbat off", 1'b0, lowBattery)
      // Second reset in mid-run must clear the written configuration
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, OFS_PIN_CFG, 32'h0);
      `CHK("mid reset", 32'h0, rdVal)
      close_out();
   end
endmodule : tb
